// >>> pkg/pmrb_regs.svh
`ifndef PMRB_REGS_SVH
`define PMRB_REGS_SVH

// Pointer addresses
`define PMRB_PTR_CONFIG 8'h00
`define PMRB_PTR_SHUNT 8'h01
`define PMRB_PTR_BUS 8'h02
`define PMRB_PTR_POWER 8'h03
`define PMRB_PTR_CURRENT 8'h04
`define PMRB_PTR_CAL 8'h05
`define PMRB_PTR_MASK 8'h06
`define PMRB_PTR_LIMIT 8'h07
`define PMRB_PTR_DIE_IDENTIFIER 8'hFF

// Reset values
`define PMRB_CONFIG_RESET 16'h4127
`define PMRB_ZERO_RESET 16'h0000
`define PMRB_CONFIG_FIXED 3'h4

// Configuration field positions
`define PMRB_CFG_RST_BIT 15
`define PMRB_CFG_FIX_HI 14
`define PMRB_CFG_FIX_LO 12
`define PMRB_CFG_AVG_HI 11
`define PMRB_CFG_AVG_LO 9
`define PMRB_CFG_BCT_HI 8
`define PMRB_CFG_BCT_LO 6
`define PMRB_CFG_SCT_HI 5
`define PMRB_CFG_SCT_LO 3
`define PMRB_CFG_MODE_HI 2
`define PMRB_CFG_MODE_LO 0
`define PMRB_MODE_CONT_BIT 2
`define PMRB_MODE_SHUNT_BIT 0
`define PMRB_MODE_BUS_BIT 1

// Bus result sign position; the stored bus result is never negative
`define PMRB_BUS_SIGN_BIT 15

// Ready flag position in the alert mask/enable register
`define PMRB_MASK_READY_BIT 3

// Arithmetic scale factors
`define PMRB_CURRENT_SHIFT 11
`define PMRB_POWER_DIVISOR 32'd20000

`endif

// >>> pkg/pmrb_pkg.sv
package pmrb_pkg;
    // One host bus event as decoded by the serial front end
    typedef struct packed {
        logic start;
        logic stop;
        logic wr_byte;
        logic rd_byte;
        logic [7:0] data;
    } pmrb_host_s;

    // One set of converter results
    typedef struct packed {
        logic shunt_valid;
        logic bus_valid;
        logic [15:0] shunt;
        logic [15:0] bus;
    } pmrb_sample_s;

    // Byte phase of a write transaction
    typedef enum logic [1:0] {
        PMRB_WR_PTR,
        PMRB_WR_MSB,
        PMRB_WR_LSB
    } pmrb_wr_e;

    // Converter sequencing
    typedef enum logic [1:0] {
        PMRB_CONV_IDLE,
        PMRB_CONV_RUN,
        PMRB_CONV_HOLD
    } pmrb_conv_e;
endpackage

// >>> logic/pmrb_bank.sv
`timescale 1ns/1ps
`include "pmrb_regs.svh"

// Functional notes
// - Powers up converting shunt and bus continuously
// - Current and power derive from shunt, bus and calibration
// - Zero calibration gives zero current and power
// - Registers move as two bytes, MSB first
// - Reading configuration never disturbs conversion
// - Configuration write holds conversion until stop
// - Fresh conversion starts with new configuration
// - Pointer 0 configuration, reset value 0x4127
// - Pointer 1 shunt result, read-only
// - Pointer 2 bus result, read-only
// - Pointer 3 power result, read-only
// - Pointer 4 current result, read-only
// - Pointer 5 calibration, read/write
// - Pointer 6 alert mask and ready flag
// - Pointer 7 alert threshold, read/write
// - Pointer 0xFF die identifier, read-only
// - Configuration fields at documented bit positions
// - Mode selects which signals are measured
// - Bit 15 resets all registers, self-clears
// - Mode codes: power-down, triggered, continuous
// - Current equals shunt times calibration over 2048
// - Power equals current times bus over 20000
module pmrb_bank #(
    parameter logic [15:0] DIE_IDENTIFIER_VALUE = 16'h4142 // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pmrb_pkg::pmrb_host_s host,
    output logic [7:0] rd_data,
    input wire pmrb_pkg::pmrb_sample_s sample,
    output logic conv_run,
    output logic conv_restart,
    output logic measure_shunt,
    output logic measure_bus,
    output logic [2:0] sample_average_select,
    output logic [2:0] bus_conversion_time,
    output logic [2:0] shunt_conversion_time,
    output logic [15:0] alert_mask_enable,
    output logic [15:0] alert_threshold
);
    import pmrb_pkg::*;

    logic [15:0] measure_config;
    logic [15:0] shunt_voltage_result;
    logic [15:0] bus_voltage_result;
    logic [15:0] power_result;
    logic [15:0] current_result;
    logic [15:0] scale_calibration;
    logic [15:0] alert_mask_reg;
    logic [7:0] pointer;
    logic [7:0] wr_msb;
    logic rd_lsb_phase;
    pmrb_wr_e wr_phase;
    pmrb_conv_e conv_state;
    logic cfg_write_pending;
    logic soft_reset;
    logic reg_write;
    logic [15:0] reg_wdata;
    logic [15:0] sel_word;
    logic triggered_done;
    logic ready_set;

    // Arithmetic shared by the current and power paths
    function automatic logic [15:0] scale_current(input logic [15:0] shunt_v,
                                                  input logic [15:0] cal);
        logic signed [32:0] prod;
        prod = $signed({shunt_v[15], shunt_v}) * $signed({1'b0, cal});
        return prod[`PMRB_CURRENT_SHIFT + 15:`PMRB_CURRENT_SHIFT];
    endfunction

    function automatic logic [15:0] scale_power(input logic [15:0] cur,
                                                input logic [15:0] bus_v);
        logic [31:0] mag;
        logic [31:0] quo;
        mag = cur[15] ? 32'(-$signed(cur)) : 32'(cur);
        quo = (mag * 32'(bus_v)) / `PMRB_POWER_DIVISOR;
        return quo[15:0];
    endfunction

    // Register image for a pointer; unmapped pointers read zero
    function automatic logic [15:0] read_word(input logic [7:0] ptr,
                                              input logic [15:0] cfg,
                                              input logic [15:0] mask);
        unique case (ptr)
            `PMRB_PTR_CONFIG: return cfg;
            `PMRB_PTR_SHUNT: return shunt_voltage_result;
            `PMRB_PTR_BUS: return bus_voltage_result;
            `PMRB_PTR_POWER: return power_result;
            `PMRB_PTR_CURRENT: return current_result;
            `PMRB_PTR_CAL: return scale_calibration;
            `PMRB_PTR_MASK: return mask;
            `PMRB_PTR_LIMIT: return alert_threshold;
            `PMRB_PTR_DIE_IDENTIFIER: return DIE_IDENTIFIER_VALUE;
            default: return `PMRB_ZERO_RESET;
        endcase
    endfunction

    // Write byte sequencing: pointer, then MSB, then LSB
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_phase <= PMRB_WR_PTR;
            wr_msb <= 8'h00;
            pointer <= 8'h00;
        end else if (host.start || host.stop) begin
            wr_phase <= PMRB_WR_PTR;
        end else if (host.wr_byte) begin
            unique case (wr_phase)
                PMRB_WR_PTR: begin
                    pointer <= host.data;
                    wr_phase <= PMRB_WR_MSB;
                end
                PMRB_WR_MSB: begin
                    wr_msb <= host.data;
                    wr_phase <= PMRB_WR_LSB;
                end
                PMRB_WR_LSB: begin
                    wr_phase <= PMRB_WR_PTR;
                end
            endcase
        end
    end

    assign reg_write = host.wr_byte && !host.start && !host.stop && wr_phase == PMRB_WR_LSB;
    assign reg_wdata = {wr_msb, host.data};
    assign soft_reset = reg_write && pointer == `PMRB_PTR_CONFIG
                        && reg_wdata[`PMRB_CFG_RST_BIT];

    // Configuration; reserved bits stay fixed, reset bit never stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_config <= `PMRB_CONFIG_RESET;
        end else if (soft_reset) begin
            measure_config <= `PMRB_CONFIG_RESET;
        end else if (reg_write && pointer == `PMRB_PTR_CONFIG) begin
            measure_config <= {1'b0, `PMRB_CONFIG_FIXED,
                               reg_wdata[`PMRB_CFG_AVG_HI:`PMRB_CFG_MODE_LO]};
        end
    end

    // Writable registers other than configuration and the alert mask
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scale_calibration <= `PMRB_ZERO_RESET;
            alert_threshold <= `PMRB_ZERO_RESET;
        end else if (soft_reset) begin
            scale_calibration <= `PMRB_ZERO_RESET;
            alert_threshold <= `PMRB_ZERO_RESET;
        end else if (reg_write) begin
            if (pointer == `PMRB_PTR_CAL) begin
                scale_calibration <= reg_wdata;
            end
            if (pointer == `PMRB_PTR_LIMIT) begin
                alert_threshold <= reg_wdata;
            end
        end
    end

    // Ready flag: a new result wins over a clearing write
    assign ready_set = conv_state == PMRB_CONV_RUN && (sample.shunt_valid || sample.bus_valid);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_mask_reg <= `PMRB_ZERO_RESET;
        end else if (soft_reset) begin
            alert_mask_reg <= `PMRB_ZERO_RESET;
        end else begin
            if (reg_write && pointer == `PMRB_PTR_MASK) begin
                alert_mask_reg <= reg_wdata;
            end
            if (ready_set) begin
                alert_mask_reg[`PMRB_MASK_READY_BIT] <= 1'b1;
            end
        end
    end
    assign alert_mask_enable = alert_mask_reg;

    // Conversion control; a config write holds the converter until stop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_state <= PMRB_CONV_RUN;
            cfg_write_pending <= 1'b0;
            conv_restart <= 1'b0;
        end else begin
            conv_restart <= 1'b0;
            if (reg_write && pointer == `PMRB_PTR_CONFIG) begin
                conv_state <= PMRB_CONV_HOLD;
                cfg_write_pending <= 1'b1;
            end else if (cfg_write_pending && host.stop) begin
                cfg_write_pending <= 1'b0;
                conv_restart <= 1'b1;
                // Both power-down codes select neither signal, so bit 2 is ignored
                conv_state <= (!measure_shunt && !measure_bus)
                              ? PMRB_CONV_IDLE : PMRB_CONV_RUN;
            end else if (triggered_done) begin
                conv_state <= PMRB_CONV_IDLE;
            end
        end
    end

    // Triggered modes stop after one result set
    assign triggered_done = conv_state == PMRB_CONV_RUN
        && !measure_config[`PMRB_MODE_CONT_BIT] && ready_set;

    assign conv_run = conv_state == PMRB_CONV_RUN;
    assign measure_shunt = measure_config[`PMRB_MODE_SHUNT_BIT];
    assign measure_bus = measure_config[`PMRB_MODE_BUS_BIT];
    assign sample_average_select = measure_config[`PMRB_CFG_AVG_HI:`PMRB_CFG_AVG_LO];
    assign bus_conversion_time = measure_config[`PMRB_CFG_BCT_HI:`PMRB_CFG_BCT_LO];
    assign shunt_conversion_time = measure_config[`PMRB_CFG_SCT_HI:`PMRB_CFG_SCT_LO];

    // Result capture only while running
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_voltage_result <= `PMRB_ZERO_RESET;
            bus_voltage_result <= `PMRB_ZERO_RESET;
        end else if (soft_reset) begin
            shunt_voltage_result <= `PMRB_ZERO_RESET;
            bus_voltage_result <= `PMRB_ZERO_RESET;
        end else if (conv_state == PMRB_CONV_RUN) begin
            if (sample.shunt_valid && measure_shunt) begin
                shunt_voltage_result <= sample.shunt;
            end
            if (sample.bus_valid && measure_bus) begin
                bus_voltage_result <= {1'b0, sample.bus[`PMRB_BUS_SIGN_BIT - 1:0]};
            end
        end
    end

    // Derived results recomputed from stored values every cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            current_result <= `PMRB_ZERO_RESET;
            power_result <= `PMRB_ZERO_RESET;
        end else if (soft_reset || scale_calibration == `PMRB_ZERO_RESET) begin
            current_result <= `PMRB_ZERO_RESET;
            power_result <= `PMRB_ZERO_RESET;
        end else begin
            current_result <= scale_current(shunt_voltage_result,
                                            scale_calibration);
            power_result <= scale_power(current_result, bus_voltage_result);
        end
    end

    // Read byte sequencing; reads change no setting or conversion state
    // Process form: the lookup also reads results that are not arguments
    always_comb begin
        sel_word = read_word(pointer, measure_config, alert_mask_reg);
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_lsb_phase <= 1'b0;
            rd_data <= 8'h00;
        end else if (host.start) begin
            rd_lsb_phase <= 1'b0;
            rd_data <= sel_word[15:8];
        end else if (host.rd_byte) begin
            rd_lsb_phase <= !rd_lsb_phase;
            rd_data <= rd_lsb_phase ? sel_word[15:8] : sel_word[7:0];
        end
    end

    // Checks sit here because they watch state from several processes above

    a_cal_zero_results: assert property (@(posedge sys_clk) disable iff (!rst_n)
        scale_calibration == `PMRB_ZERO_RESET ##1 scale_calibration == `PMRB_ZERO_RESET
        |-> current_result == `PMRB_ZERO_RESET && power_result == `PMRB_ZERO_RESET)
        else $error("current or power nonzero with zero calibration");

    a_cfg_write_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_write && pointer == `PMRB_PTR_CONFIG |=> !conv_run && cfg_write_pending)
        else $error("conversion runs during config write");

    a_restart_after_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_write_pending && host.stop && !reg_write |=> conv_restart)
        else $error("no restart after config write");

    a_soft_reset_cfg: assert property (@(posedge sys_clk) disable iff (!rst_n)
        soft_reset |=> measure_config == `PMRB_CONFIG_RESET
        && scale_calibration == `PMRB_ZERO_RESET && alert_threshold == `PMRB_ZERO_RESET)
        else $error("soft reset did not restore defaults");

    a_rst_bit_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !measure_config[`PMRB_CFG_RST_BIT]
        && measure_config[`PMRB_CFG_FIX_HI:`PMRB_CFG_FIX_LO] == `PMRB_CONFIG_FIXED)
        else $error("config fixed bits wrong");

    a_pointer_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host.wr_byte && !host.start && !host.stop && wr_phase == PMRB_WR_PTR
        |=> pointer == $past(host.data))
        else $error("pointer not stored");

    a_read_no_effect: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host.rd_byte && !host.wr_byte && !host.start && !ready_set
        && conv_state != PMRB_CONV_HOLD |=> $stable(measure_config) && $stable(conv_state))
        else $error("read disturbed configuration");

    a_power_down_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv_restart && !measure_shunt && !measure_bus |-> !conv_run)
        else $error("power-down mode still running");

    a_current_calc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        scale_calibration != `PMRB_ZERO_RESET && !soft_reset
        |=> current_result == scale_current($past(shunt_voltage_result),
                                            $past(scale_calibration)))
        else $error("current result mismatch");

    a_power_calc: assert property (@(posedge sys_clk) disable iff (!rst_n)
        scale_calibration != `PMRB_ZERO_RESET && !soft_reset
        |=> power_result == scale_power($past(current_result), $past(bus_voltage_result)))
        else $error("power result mismatch");

    a_bus_sign_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !bus_voltage_result[`PMRB_BUS_SIGN_BIT])
        else $error("bus result sign bit set");

    a_trig_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv_run && !measure_config[`PMRB_MODE_CONT_BIT] && ready_set |=> !conv_run)
        else $error("triggered mode kept running");

    a_hold_no_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !conv_run && !soft_reset
        |=> $stable(shunt_voltage_result) && $stable(bus_voltage_result))
        else $error("result captured while converter stopped");

    a_restart_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        conv_restart |=> !conv_restart)
        else $error("restart pulse longer than one cycle");

    a_read_msb_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host.start |=> rd_data == $past(sel_word[15:8]))
        else $error("read did not open with the high byte");

    a_read_lsb_next: assert property (@(posedge sys_clk) disable iff (!rst_n)
        host.rd_byte && !host.start && !rd_lsb_phase
        |=> rd_data == $past(sel_word[7:0]))
        else $error("second read byte is not the low byte");

    a_ready_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ready_set && !soft_reset |=> alert_mask_reg[`PMRB_MASK_READY_BIT])
        else $error("ready flag not set by a result");

    a_cal_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_write && pointer == `PMRB_PTR_CAL |=> scale_calibration == $past(reg_wdata))
        else $error("calibration write lost");
endmodule

// >>> tb/pmrb_host_model.sv
`timescale 1ns/1ps
// Serial host stand-in issuing decoded bus events one at a time
module pmrb_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] rd_data,
    output pmrb_pkg::pmrb_host_s host
);
    import pmrb_pkg::*;
    localparam logic [3:0] EV_START = 4'h8;
    localparam logic [3:0] EV_STOP = 4'h4;
    localparam logic [3:0] EV_WR = 4'h2;
    localparam logic [3:0] EV_RD = 4'h1;

    initial host = '0;

    // One pulse then idle; idle data flips so a stale byte never looks valid
    task automatic ev(input logic [3:0] k, input logic [7:0] d);
        @(posedge sys_clk);
        host <= '{start: k[3], stop: k[2], wr_byte: k[1], rd_byte: k[0], data: d};
        @(posedge sys_clk);
        host <= '{start: 1'b0, stop: 1'b0, wr_byte: 1'b0, rd_byte: 1'b0, data: ~d};
    endtask

    // Pointer then data, MSB before LSB, no stop yet
    task automatic write_open(input logic [7:0] p, input logic [15:0] val);
        ev(EV_START, 8'h00);
        ev(EV_WR, p);
        ev(EV_WR, val[15:8]);
        ev(EV_WR, val[7:0]);
    endtask

    task automatic write_reg(input logic [7:0] p, input logic [15:0] val);
        write_open(p, val);
        ev(EV_STOP, 8'h00);
    endtask

    // Pointer write, then a fresh read returning MSB then LSB
    task automatic read_reg(input logic [7:0] p, output logic [15:0] val);
        ev(EV_START, 8'h00);
        ev(EV_WR, p);
        ev(EV_STOP, 8'h00);
        ev(EV_START, 8'h00);
        #1 val[15:8] = rd_data;
        ev(EV_RD, 8'h00);
        #1 val[7:0] = rd_data;
        ev(EV_STOP, 8'h00);
    endtask
endmodule

// >>> tb/power_monitor_register_bank_bench.sv
`timescale 1ns/1ps
module power_monitor_register_bank_bench;
    import pmrb_pkg::*;
    localparam logic [15:0] DIE = 16'h5A3C; // Arbitrary value
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    pmrb_sample_s sample = '0;
    pmrb_host_s host;
    logic [7:0] rd_data;
    logic conv_run, conv_restart, measure_shunt, measure_bus;
    logic [2:0] mean_sel, bus_time, shunt_time;
    logic [15:0] mask, thr;
    int miscompares = 0;
    int samples_checked = 0;

    pmrb_bank #(.DIE_IDENTIFIER_VALUE(DIE)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .host(host), .rd_data(rd_data), .sample(sample), .conv_run(conv_run),
        .conv_restart(conv_restart), .measure_shunt(measure_shunt),
        .measure_bus(measure_bus), .sample_average_select(mean_sel),
        .bus_conversion_time(bus_time), .shunt_conversion_time(shunt_time),
        .alert_mask_enable(mask), .alert_threshold(thr));
    pmrb_host_model host_u (.sys_clk(sys_clk), .rd_data(rd_data), .host(host));

    // 250 MHz
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
        logic [15:0] got;
        host_u.read_reg(p, got);
        chk($sformatf("reg_%h", p), e, got);
    endtask

    // Result pulse; words flip afterwards so only the valid cycle matters
    task automatic smp(input logic [15:0] s, input logic [15:0] b);
        @(posedge sys_clk);
        sample <= '{shunt_valid: 1'b1, bus_valid: 1'b1, shunt: s, bus: b};
        @(posedge sys_clk);
        sample <= '{shunt_valid: 1'b0, bus_valid: 1'b0, shunt: ~s, bus: ~b};
        #1;
    endtask

    task automatic t_reset();
        chk("conv_run", 16'h0001, conv_run);
        chk("measure", 16'h0003, {measure_bus, measure_shunt});
        chk("fields", 16'h0024, {mean_sel, bus_time, shunt_time});
        rd_chk(8'h00, 16'h4127);
        rd_chk(8'h01, 16'h0000);
        rd_chk(8'h02, 16'h0000);
        rd_chk(8'h03, 16'h0000);
        rd_chk(8'h04, 16'h0000);
        rd_chk(8'h05, 16'h0000);
        rd_chk(8'h06, 16'h0000);
        rd_chk(8'h07, 16'h0000);
        rd_chk(8'hFF, DIE);
        rd_chk(8'h08, 16'h0000);
    endtask

    // Writes to read-only places must leave them untouched
    task automatic t_readonly();
        logic [7:0] ro [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'hFF};
        foreach (ro[i]) host_u.write_reg(ro[i], 16'hFFFF);
        foreach (ro[i]) rd_chk(ro[i], (ro[i] == 8'hFF) ? DIE : 16'h0000);
    endtask

    // Worked example; the second bus word also carries a stray sign bit
    task automatic t_calc();
        smp(16'h3E80, 16'h2560);
        rd_chk(8'h01, 16'h3E80);
        rd_chk(8'h02, 16'h2560);
        rd_chk(8'h04, 16'h0000);
        rd_chk(8'h03, 16'h0000);
        host_u.write_reg(8'h05, 16'h0A00);
        rd_chk(8'h05, 16'h0A00);
        smp(16'h3E80, 16'hA560);
        rd_chk(8'h02, 16'h2560);
        rd_chk(8'h04, 16'h4E20);
        rd_chk(8'h03, 16'h2560);
    endtask

    // Converter held from the data write until stop, then restarted
    task automatic t_cfg();
        host_u.write_open(8'h00, 16'h7A5F);
        #1 chk("conv_run", 16'h0000, conv_run);
        smp(16'h1111, 16'h2222);
        chk("conv_run", 16'h0000, conv_run);
        host_u.ev(4'h4, 8'h00);
        #1 chk("conv_restart", 16'h0001, conv_restart);
        chk("conv_run", 16'h0001, conv_run);
        chk("fields", 16'h014B, {mean_sel, bus_time, shunt_time});
        rd_chk(8'h01, 16'h3E80);
        rd_chk(8'h00, 16'h4A5F);
        chk("conv_restart", 16'h0000, conv_restart);
        chk("conv_run", 16'h0001, conv_run);
        smp(16'h0100, 16'h0200);
        rd_chk(8'h01, 16'h0100);
    endtask

    // Every mode code; triggered modes stop after one result
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            host_u.write_reg(8'h00, 16'h0120 | m[15:0]);
            #1 chk("measure", {14'h0, m[1:0]}, {measure_bus, measure_shunt});
            chk("conv_run", {15'h0, m[1:0] != 2'h0}, conv_run);
            smp(16'h0040, 16'h0080);
            chk("conv_run", {15'h0, m[2] && m[1:0] != 2'h0}, conv_run);
        end
    endtask

    task automatic t_alert();
        host_u.write_reg(8'h06, 16'h4C11);
        rd_chk(8'h06, 16'h4C11);
        chk("mask", 16'h4C11, mask);
        smp(16'h0040, 16'h0080);
        rd_chk(8'h06, 16'h4C19);
        host_u.write_reg(8'h07, 16'hBEEF);
        rd_chk(8'h07, 16'hBEEF);
        chk("threshold", 16'hBEEF, thr);
    endtask

    // Self-clearing reset bit restores every default
    task automatic t_soft();
        host_u.write_reg(8'h00, 16'h8000);
        rd_chk(8'h00, 16'h4127);
        rd_chk(8'h05, 16'h0000);
        rd_chk(8'h01, 16'h0000);
        chk("mask", 16'h0000, mask);
        chk("threshold", 16'h0000, thr);
        host_u.write_reg(8'h05, 16'h0A00);
        rd_chk(8'h05, 16'h0A00);
    endtask

    // Mid-run power loss: nothing written before survives
    task automatic t_hwreset();
        host_u.write_reg(8'h07, 16'h1234);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk("conv_run", 16'h0001, conv_run);
        chk("threshold", 16'h0000, thr);
        rd_chk(8'h07, 16'h0000);
        rd_chk(8'h05, 16'h0000);
        rd_chk(8'h00, 16'h4127);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reset for 20 cycles, then every scenario in turn
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_readonly();
        t_calc();
        t_cfg();
        t_modes();
        t_alert();
        t_soft();
        t_hwreset();
        conclude();
    end
endmodule
